/* File: hdl/dac_ctrl_pkg.sv */
// ==========================================================================
// Shared constants and carriers of the converter control block.
// ==========================================================================
package dac_ctrl_pkg;

    // ======================================================================
    // Register map.
    // ======================================================================
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 2'h0;
    localparam logic [ADDR_W-1:0] RESERVED_OFFSET = 2'h1;
    localparam logic [ADDR_W-1:0] CODE_LEFT_OFFSET = 2'h2;
    localparam logic [ADDR_W-1:0] CODE_RIGHT_OFFSET = 2'h3;

    // ======================================================================
    // Control register field positions.
    // ======================================================================
    localparam int CONVERTER_ENABLE_POS = 7;
    localparam int FACTORY_TEST_ENABLE_POS = 6;
    localparam int JUSTIFY_SELECT_POS = 3;
    localparam int SIGN_SELECT_POS = 2;
    localparam int WAIT_POWER_DOWN_POS = 1;
    localparam int OUTPUT_PIN_ENABLE_POS = 0;

    // ======================================================================
    // Reset values, fixed read values and the sign flip mask.
    // ======================================================================
    localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CODE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] RESERVED_READ = 8'h00;
    localparam logic [DATA_W-1:0] SIGN_FLIP = 8'h80;

    // ======================================================================
    // Carriers.
    // ======================================================================
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic converter_enable;
        logic factory_test_enable;
        logic justify_select;
        logic sign_select;
        logic wait_power_down;
        logic output_pin_enable;
    } control_t;

    typedef struct packed {
        logic special_mode;
        logic wait_mode;
        logic stop_mode;
    } system_mode_t;

endpackage

/* File: hdl/dac_register_control.sv */
`timescale 1ns/10ps
module dac_register_control (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire dac_ctrl_pkg::reg_req_t req_i,
    input wire dac_ctrl_pkg::system_mode_t mode_i,
    output logic [dac_ctrl_pkg::DATA_W-1:0] rd_data_o,
    output logic [dac_ctrl_pkg::DATA_W-1:0] conv_code_o,
    output logic conv_power_o,
    output logic conv_test_o,
    output logic analog_output_pin_oe_o
);

    // ======================================================================
    // Helper functions.
    // ======================================================================

    // Maps a stored code onto the straight binary scale of the core.
    function automatic logic [dac_ctrl_pkg::DATA_W-1:0] to_binary(
        input logic [dac_ctrl_pkg::DATA_W-1:0] code,
        input logic is_signed
    );
        to_binary = is_signed ? (code ^ dac_ctrl_pkg::SIGN_FLIP) : code;
    endfunction

    // Packs the control fields into their register positions.
    function automatic logic [dac_ctrl_pkg::DATA_W-1:0] pack_control(
        input dac_ctrl_pkg::control_t c
    );
        logic [dac_ctrl_pkg::DATA_W-1:0] v;
        v = '0;
        v[dac_ctrl_pkg::CONVERTER_ENABLE_POS] = c.converter_enable;
        v[dac_ctrl_pkg::FACTORY_TEST_ENABLE_POS] = c.factory_test_enable;
        v[dac_ctrl_pkg::JUSTIFY_SELECT_POS] = c.justify_select;
        v[dac_ctrl_pkg::SIGN_SELECT_POS] = c.sign_select;
        v[dac_ctrl_pkg::WAIT_POWER_DOWN_POS] = c.wait_power_down;
        v[dac_ctrl_pkg::OUTPUT_PIN_ENABLE_POS] = c.output_pin_enable;
        pack_control = v;
    endfunction

    // ======================================================================
    // Register state.
    // ======================================================================
    dac_ctrl_pkg::control_t control_reg;
    dac_ctrl_pkg::control_t control_next;
    logic [dac_ctrl_pkg::DATA_W-1:0] code_left_reg;
    logic [dac_ctrl_pkg::DATA_W-1:0] code_left_next;
    logic [dac_ctrl_pkg::DATA_W-1:0] code_right_reg;
    logic [dac_ctrl_pkg::DATA_W-1:0] code_right_next;
    logic [dac_ctrl_pkg::DATA_W-1:0] rd_data_reg;
    logic [dac_ctrl_pkg::DATA_W-1:0] rd_data_next;
    logic wr_control;
    logic wr_left;
    logic wr_right;

    // Decodes writes; a data view only accepts writes while it is selected.
    always_comb begin
        wr_control = req_i.wr && (req_i.addr == dac_ctrl_pkg::CONTROL_OFFSET);
        wr_left = req_i.wr && !control_reg.justify_select
            && (req_i.addr == dac_ctrl_pkg::CODE_LEFT_OFFSET);
        wr_right = req_i.wr && control_reg.justify_select
            && (req_i.addr == dac_ctrl_pkg::CODE_RIGHT_OFFSET);
    end

    // Computes the next register values from the bus writes.
    always_comb begin
        control_next = control_reg;
        code_left_next = code_left_reg;
        code_right_next = code_right_reg;
        if (wr_control) begin
            control_next.converter_enable =
                req_i.wdata[dac_ctrl_pkg::CONVERTER_ENABLE_POS];
            control_next.justify_select =
                req_i.wdata[dac_ctrl_pkg::JUSTIFY_SELECT_POS];
            control_next.sign_select =
                req_i.wdata[dac_ctrl_pkg::SIGN_SELECT_POS];
            control_next.wait_power_down =
                req_i.wdata[dac_ctrl_pkg::WAIT_POWER_DOWN_POS];
            control_next.output_pin_enable =
                req_i.wdata[dac_ctrl_pkg::OUTPUT_PIN_ENABLE_POS];
            if (mode_i.special_mode) begin
                control_next.factory_test_enable =
                    req_i.wdata[dac_ctrl_pkg::FACTORY_TEST_ENABLE_POS];
            end
        end
        // Each view keeps its own code, so flipping justification loses none.
        if (wr_left) begin
            code_left_next = req_i.wdata;
        end
        if (wr_right) begin
            code_right_next = req_i.wdata;
        end
    end

    // Computes the read answer, which stands only in the following cycle.
    always_comb begin
        rd_data_next = '0;
        if (req_i.rd) begin
            case (req_i.addr)
                dac_ctrl_pkg::CONTROL_OFFSET: begin
                    rd_data_next = pack_control(control_reg);
                end
                dac_ctrl_pkg::RESERVED_OFFSET: begin
                    rd_data_next = dac_ctrl_pkg::RESERVED_READ;
                end
                dac_ctrl_pkg::CODE_LEFT_OFFSET: begin
                    rd_data_next = control_reg.justify_select ?
                        '0 : code_left_reg;
                end
                dac_ctrl_pkg::CODE_RIGHT_OFFSET: begin
                    rd_data_next = control_reg.justify_select ?
                        code_right_reg : '0;
                end
                default: begin
                    rd_data_next = '0;
                end
            endcase
        end
    end

    // Registers the software-visible state; reset clears it all.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_reg <= dac_ctrl_pkg::control_t'(6'h00);
            code_left_reg <= dac_ctrl_pkg::CODE_RESET;
            code_right_reg <= dac_ctrl_pkg::CODE_RESET;
            rd_data_reg <= '0;
        end else begin
            control_reg <= control_next;
            code_left_reg <= code_left_next;
            code_right_reg <= code_right_next;
            rd_data_reg <= rd_data_next;
        end
    end

    // ======================================================================
    // Converter steering.
    // ======================================================================
    logic power_next;
    logic pin_oe_next;
    logic [dac_ctrl_pkg::DATA_W-1:0] selected_code;
    logic [dac_ctrl_pkg::DATA_W-1:0] code_next;
    logic power_reg;
    logic pin_oe_reg;
    logic test_reg;
    logic [dac_ctrl_pkg::DATA_W-1:0] code_reg;

    // Decides whether the core runs and which code it converts.
    always_comb begin
        power_next = control_reg.converter_enable
            && !mode_i.stop_mode
            && !(mode_i.wait_mode && control_reg.wait_power_down);
        pin_oe_next = power_next && control_reg.output_pin_enable;
        selected_code = control_reg.justify_select ?
            code_right_reg : code_left_reg;
        code_next = power_next ?
            to_binary(selected_code, control_reg.sign_select) : '0;
    end

    // Registers the signals handed to the analog core.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            test_reg <= 1'b0;
            code_reg <= dac_ctrl_pkg::CODE_RESET;
        end else begin
            power_reg <= power_next;
            pin_oe_reg <= pin_oe_next;
            test_reg <= control_reg.factory_test_enable;
            code_reg <= code_next;
        end
    end

    // Drives the outputs straight from their flip-flops.
    assign rd_data_o = rd_data_reg;
    assign conv_code_o = code_reg;
    assign conv_power_o = power_reg;
    assign conv_test_o = test_reg;
    assign analog_output_pin_oe_o = pin_oe_reg;

    // ======================================================================
    // Assertions.
    // ======================================================================
    // Checks sample at the rising edge and stay quiet while reset is low.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    power_follows_a: assert property (
        conv_power_o == $past(power_next))
        else $error("Converter power does not follow the enable.");

    pin_needs_both_a: assert property (
        analog_output_pin_oe_o |-> $past(control_reg.converter_enable)
            && $past(control_reg.output_pin_enable))
        else $error("Output pin driven without both enables.");

    test_guarded_a: assert property (
        wr_control && !mode_i.special_mode |=> $stable(
            control_reg.factory_test_enable))
        else $error("Test enable changed outside special mode.");

    left_blocked_a: assert property (
        control_reg.justify_select |=> $stable(code_left_reg))
        else $error("Left view written while right is selected.");

    right_blocked_a: assert property (
        !control_reg.justify_select |=> $stable(code_right_reg))
        else $error("Right view written while left is selected.");

    left_read_zero_a: assert property (
        req_i.rd && control_reg.justify_select
            && req_i.addr == dac_ctrl_pkg::CODE_LEFT_OFFSET
            |=> rd_data_o == '0)
        else $error("Hidden left view did not read zero.");

    reserved_zero_a: assert property (
        req_i.rd && req_i.addr == dac_ctrl_pkg::RESERVED_OFFSET
            |=> rd_data_o == '0)
        else $error("Reserved register read nonzero.");

    write_read_a: assert property (
        req_i.wr && req_i.addr == dac_ctrl_pkg::CONTROL_OFFSET
            ##1 req_i.rd && req_i.addr == dac_ctrl_pkg::CONTROL_OFFSET
            |=> rd_data_o[dac_ctrl_pkg::CONVERTER_ENABLE_POS] ==
                $past(req_i.wdata[dac_ctrl_pkg::CONVERTER_ENABLE_POS], 2)
            && rd_data_o[dac_ctrl_pkg::FACTORY_TEST_ENABLE_POS-1:
                dac_ctrl_pkg::JUSTIFY_SELECT_POS+1] == 2'h0
            && rd_data_o[dac_ctrl_pkg::JUSTIFY_SELECT_POS:
                dac_ctrl_pkg::OUTPUT_PIN_ENABLE_POS] ==
                $past(req_i.wdata[dac_ctrl_pkg::JUSTIFY_SELECT_POS:
                    dac_ctrl_pkg::OUTPUT_PIN_ENABLE_POS], 2))
        else $error("Control read does not show the last write.");

    idle_read_zero_a: assert property (
        !$past(req_i.rd) |-> rd_data_o == '0)
        else $error("Read data present without a read.");

    wait_power_a: assert property (
        mode_i.wait_mode && control_reg.wait_power_down
            |=> !conv_power_o && !analog_output_pin_oe_o)
        else $error("Converter running in wait with power-down set.");

    stop_hold_a: assert property (
        mode_i.stop_mode && !req_i.wr |=> !conv_power_o
            && $stable(code_left_reg) && $stable(code_right_reg))
        else $error("Stop mode did not disable or kept no registers.");

    signed_map_a: assert property (
        power_next && control_reg.sign_select |=> conv_code_o ==
            ($past(selected_code) ^ dac_ctrl_pkg::SIGN_FLIP))
        else $error("Signed code not mapped to binary scale.");

    view_keep_a: assert property (
        $changed(control_reg.justify_select)
            |-> $stable(code_left_reg) && $stable(code_right_reg))
        else $error("Justification change disturbed stored codes.");

    right_read_zero_a: assert property (
        req_i.rd && !control_reg.justify_select
            && req_i.addr == dac_ctrl_pkg::CODE_RIGHT_OFFSET
            |=> rd_data_o == '0)
        else $error("Hidden right view did not read zero.");

    code_off_zero_a: assert property (
        !power_next |=> conv_code_o == '0)
        else $error("Code handed to a powered-down converter.");

    left_feeds_a: assert property (
        power_next && !control_reg.sign_select
            && !control_reg.justify_select
            |=> conv_code_o == $past(code_left_reg))
        else $error("Left view not handed to the converter.");

    right_feeds_a: assert property (
        power_next && !control_reg.sign_select
            && control_reg.justify_select
            |=> conv_code_o == $past(code_right_reg))
        else $error("Right view not handed to the converter.");

    oe_off_a: assert property (
        !control_reg.output_pin_enable |=> !analog_output_pin_oe_o)
        else $error("Output pin driven with its enable clear.");

    // Covers mark the main scenarios: right view, pin, wait, signed, bus.
    right_conv_c: cover property (
        control_reg.justify_select && power_next ##1 conv_power_o);
    pin_on_c: cover property (analog_output_pin_oe_o);
    wait_down_c: cover property (
        conv_power_o ##1 mode_i.wait_mode && !conv_power_o);
    signed_conv_c: cover property (
        control_reg.sign_select && power_next ##1 conv_power_o);
    back_to_back_c: cover property (req_i.wr ##1 req_i.rd);

endmodule // dac_register_control

/* File: test/dac_register_control_bench.sv */
`timescale 1ns/10ps
module dac_register_control_bench;
    // ======================================================================
    // Stimulus rows and bench signals.
    // ======================================================================
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] code;
        logic [2:0] mode;
        logic [7:0] exp_ctrl;
        logic [7:0] exp_code;
        logic exp_power;
        logic exp_oe;
    } row_t;

    // Mode field order is special, wait, stop.
    row_t rows [12] = '{
        '{8'hc1, 8'h11, 3'h0, 8'h81, 8'h11, 1'b1, 1'b1},
        '{8'hb1, 8'h5a, 3'h0, 8'h81, 8'h5a, 1'b1, 1'b1},
        '{8'h8d, 8'h7f, 3'h0, 8'h8d, 8'hff, 1'b1, 1'b1},
        '{8'h84, 8'h80, 3'h0, 8'h84, 8'h00, 1'b1, 1'b0},
        '{8'h83, 8'h3c, 3'h2, 8'h83, 8'h00, 1'b0, 1'b0},
        '{8'h81, 8'hff, 3'h2, 8'h81, 8'hff, 1'b1, 1'b1},
        '{8'h81, 8'h01, 3'h1, 8'h81, 8'h00, 1'b0, 1'b0},
        '{8'h01, 8'h33, 3'h0, 8'h01, 8'h00, 1'b0, 1'b0},
        '{8'hc1, 8'h12, 3'h4, 8'hc1, 8'h12, 1'b1, 1'b1},
        '{8'h81, 8'h12, 3'h0, 8'hc1, 8'h12, 1'b1, 1'b1},
        '{8'h89, 8'h00, 3'h4, 8'h89, 8'h00, 1'b1, 1'b1},
        '{8'hc9, 8'hfe, 3'h0, 8'h89, 8'hfe, 1'b1, 1'b1}
    };
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    dac_ctrl_pkg::reg_req_t req = '0;
    dac_ctrl_pkg::system_mode_t mode = '0;
    logic [7:0] rd_data;
    logic [7:0] conv_code;
    logic conv_power;
    logic conv_test;
    logic pin_oe;
    int mismatches = 0;
    int total_checks = 0;

    dac_register_control dac_register_control_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .req_i(req),
        .mode_i(mode),
        .rd_data_o(rd_data),
        .conv_code_o(conv_code),
        .conv_power_o(conv_power),
        .conv_test_o(conv_test),
        .analog_output_pin_oe_o(pin_oe)
    );

    // The clock toggles every half period of 50 ns.
    always #50 clk_i = ~clk_i;

    // ======================================================================
    // Shared tasks.
    // ======================================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic write_reg(input logic [1:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        req.addr <= addr;
        req.wdata <= data;
        req.wr <= 1'b1;
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask

    // Read data must stand one cycle only and fall back to zero after it.
    task automatic read_check(input logic [1:0] addr, input logic [7:0] exp);
        @(posedge clk_i);
        req.addr <= addr;
        req.rd <= 1'b1;
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        check(rd_data, exp);
        @(posedge clk_i);
        #1;
        check(rd_data, 8'h00);
    endtask

    task automatic out_check(input logic [7:0] code, input logic pw,
                             input logic oe, input logic te);
        @(posedge clk_i);
        #1;
        check(conv_code, code);
        check({7'h00, conv_power}, {7'h00, pw});
        check({7'h00, pin_oe}, {7'h00, oe});
        check({7'h00, conv_test}, {7'h00, te});
    endtask

    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The watchdog cuts a hang short well beyond the expected run length.
    initial begin
        #(3000 * 100);
        mismatches++;
        end_of_test();
    end

    // ======================================================================
    // Main sequence: table rows first, then the hand-written cases.
    // ======================================================================
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        read_check(dac_ctrl_pkg::CONTROL_OFFSET, 8'h00);
        read_check(dac_ctrl_pkg::CODE_LEFT_OFFSET, 8'h00);
        foreach (rows[i]) begin
            @(posedge clk_i);
            mode <= rows[i].mode;
            write_reg(dac_ctrl_pkg::CONTROL_OFFSET, rows[i].ctrl);
            write_reg(dac_ctrl_pkg::CODE_LEFT_OFFSET, rows[i].code);
            write_reg(dac_ctrl_pkg::CODE_RIGHT_OFFSET, rows[i].code);
            out_check(rows[i].exp_code, rows[i].exp_power, rows[i].exp_oe,
                      rows[i].exp_ctrl[6]);
            read_check(2'h0, rows[i].exp_ctrl);
            read_check(rows[i].exp_ctrl[3] ? 2'h3 : 2'h2, rows[i].code);
            read_check(rows[i].exp_ctrl[3] ? 2'h2 : 2'h3, 8'h00);
        end
        // Stored code survives a change of justification either way.
        write_reg(dac_ctrl_pkg::CONTROL_OFFSET, 8'h81);
        write_reg(dac_ctrl_pkg::CODE_LEFT_OFFSET, 8'ha5);
        write_reg(dac_ctrl_pkg::CONTROL_OFFSET, 8'h89);
        write_reg(dac_ctrl_pkg::CODE_RIGHT_OFFSET, 8'h5a);
        write_reg(dac_ctrl_pkg::CONTROL_OFFSET, 8'h81);
        out_check(8'ha5, 1'b1, 1'b1, 1'b0);
        read_check(dac_ctrl_pkg::CODE_LEFT_OFFSET, 8'ha5);
        write_reg(dac_ctrl_pkg::CODE_RIGHT_OFFSET, 8'hff);
        write_reg(dac_ctrl_pkg::CONTROL_OFFSET, 8'h89);
        read_check(dac_ctrl_pkg::CODE_RIGHT_OFFSET, 8'h5a);
        // The reserved register holds nothing.
        write_reg(dac_ctrl_pkg::RESERVED_OFFSET, 8'hff);
        read_check(dac_ctrl_pkg::RESERVED_OFFSET, 8'h00);
        // Stop mode powers down but keeps every register.
        @(posedge clk_i);
        mode <= 3'h1;
        read_check(dac_ctrl_pkg::CONTROL_OFFSET, 8'h89);
        out_check(8'h00, 1'b0, 1'b0, 1'b0);
        read_check(dac_ctrl_pkg::CODE_RIGHT_OFFSET, 8'h5a);
        @(posedge clk_i);
        mode <= 3'h0;
        @(posedge clk_i);
        out_check(8'h5a, 1'b1, 1'b1, 1'b0);
        // A hidden left write is dropped; a read may follow a write at once.
        write_reg(dac_ctrl_pkg::CODE_LEFT_OFFSET, 8'hff);
        @(posedge clk_i);
        req.addr <= dac_ctrl_pkg::CONTROL_OFFSET;
        req.wdata <= 8'h85;
        req.wr <= 1'b1;
        @(posedge clk_i);
        req.wr <= 1'b0;
        req.rd <= 1'b1;
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        check(rd_data, 8'h85);
        read_check(dac_ctrl_pkg::CODE_LEFT_OFFSET, 8'ha5);
        out_check(8'h25, 1'b1, 1'b1, 1'b0);
        // A reset in mid-run clears outputs at once and all registers.
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        #1;
        out_check(8'h00, 1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        read_check(dac_ctrl_pkg::CONTROL_OFFSET, 8'h00);
        read_check(dac_ctrl_pkg::CODE_LEFT_OFFSET, 8'h00);
        write_reg(dac_ctrl_pkg::CONTROL_OFFSET, 8'h89);
        read_check(dac_ctrl_pkg::CODE_RIGHT_OFFSET, 8'h00);
        end_of_test();
    end
endmodule // dac_register_control_bench
